// ---- tcc_host_model.sv ----
`timescale 1ns/100ps
module tcc_host_model
(
  // handshake
  input  wire logic       clk_in,
  input  wire logic       ready_in,
  output logic            valid_out = 1'b0,
  output logic [6:0]      char_out = 7'h00,
  output logic            line_out = 1'b0
);
  // offer one character after gap + 1 idle cycles, hold until taken
  task automatic send(input logic [6:0] c, input logic ln, input int gap);
    repeat (gap + 1) @(posedge clk_in);
    valid_out <= 1'b1;
    char_out  <= c;
    line_out  <= ln;
    do
      @(posedge clk_in);
    while (ready_in !== 1'b1);
    valid_out <= 1'b0;
    char_out  <= ~c;
  endtask
endmodule

// ---- tcc_interp.sv ----
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module tcc_interp
  import tcc_pkg::*;
#(
  parameter int unsigned P_BIT_CYC_110  = CLK_HZ / BAUD_110,
  parameter int unsigned P_BIT_CYC_150  = CLK_HZ / BAUD_150,
  parameter int unsigned P_BIT_CYC_300  = CLK_HZ / BAUD_300,
  parameter int unsigned P_BIT_CYC_600  = CLK_HZ / BAUD_600,
  parameter int unsigned P_BIT_CYC_1200 = CLK_HZ / BAUD_1200
)
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // character stream
  input  wire logic        rx_valid_in,
  input  wire logic [6:0]  rx_char_in,
  input  wire logic        rx_from_line_in,
  output logic             rx_ready_out,
  // front panel
  input  wire logic        reset_button_in,
  input  wire logic        foreground_clear_key_in,
  output logic             print_lamp_out,
  output logic             xmit_lamp_out,
  output logic             blink_out,
  // display memory
  input  wire logic        mem_bg_in,
  output logic [4:0]       cur_row_out,
  output logic [6:0]       cur_col_out,
  output logic             op_valid_out,
  output logic [3:0]       op_code_out,
  output logic [6:0]       op_char_out,
  output logic             op_bg_out
);

  ////////////////////////////////////////////////////////////////////////////
  // types and functions
  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_LEAD   = 4'b0001,
    S_ADDR1  = 4'b0010,
    S_ADDR2  = 4'b0011,
    S_WAITBG = 4'b0100,
    S_ROLL   = 4'b0101,
    S_TAB_BG = 4'b0110,
    S_TAB_FG = 4'b0111,
    S_PRINT  = 4'b1000,
    S_SCAN   = 4'b1001
  } tcc_state_t;

  typedef enum logic [1:0] {
    P_CHAR = 2'b00,
    P_CR   = 2'b01,
    P_INS  = 2'b10,
    P_DEL  = 2'b11
  } tcc_pend_t;

  function automatic logic is_cmd(input logic [6:0] c);
    is_cmd = (c == HOME_COMMAND_CODE) || (c == ROLL_DOWN_CODE) ||
             (c == ALTERNATE_ROLL_DOWN_CODE) || (c == ROLL_UP_CODE) ||
             (c == FOREGROUND_CLEAR_CODE) || (c == FULL_CLEAR_CODE) ||
             (c == CURSOR_ADDRESS_CODE) || (c == FOREGROUND_ENTRY_CODE) ||
             (c == BACKGROUND_ENTRY_CODE) || (c == PRINT_START_CODE) ||
             (c == TRANSMIT_START_CODE);
  endfunction

  function automatic logic at_end(input logic [4:0] r, input logic [6:0] c);
    at_end = (r == LAST_ROW) && (c == LAST_COL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  tcc_state_t  state_r;
  tcc_pend_t   pend_r;
  logic [5:0]  ctrl_r;
  logic [4:0]  row_r;
  logic [6:0]  col_r;
  logic [6:0]  char_r;
  logic        line_r;
  logic        fg_entry_r;
  logic        blink_r;
  logic        print_r;
  logic        xmit_r;
  logic        key_pend_r;
  logic        scan_wait_r;
  logic        sym2_r;
  logic        ready_r;
  logic        op_valid_r;
  tcc_op_t     op_code_r;
  logic [6:0]  op_char_r;
  logic        op_bg_r;
  logic [DIV_W-1:0] div_r;
  logic [3:0]  bitcnt_r;
  logic        char_tick_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic       accept      = rx_valid_in && ready_r;
  wire logic       end_pos     = at_end(row_r, col_r);
  wire logic       local_echo  = ctrl_r[CTRL_LOCAL_ECHO];
  wire logic       local_edit  = ctrl_r[CTRL_LOCAL_EDIT];
  wire logic       full_dup    = ctrl_r[CTRL_FULL_DUP];
  wire logic [2:0] baud_sel    = ctrl_r[CTRL_BAUD_LSB +: 3];
  wire logic       entry_bg    = !fg_entry_r || (full_dup && line_r);
  wire logic       protect     = local_edit && mem_bg_in && !line_r;
  wire logic [6:0] next_col    = (col_r == LAST_COL) ? 7'h00 : col_r + 7'h01;
  wire logic [4:0] next_row    = (col_r == LAST_COL) ? row_r + 5'h01 : row_r;
  wire logic [6:0] addr_col    = (rx_char_in > LAST_COL) ? LAST_COL : rx_char_in;
  wire logic [4:0] addr_row    = (rx_char_in[4:0] > LAST_ROW) ? LAST_ROW : rx_char_in[4:0];
  wire logic       apb_setup   = psel_in && !penable_in;
  wire logic       apb_wr      = psel_in && penable_in && pready_r && pwrite_in;
  wire logic       hit_ctrl    = paddr_in == CTRL_OFS;
  wire logic       hit_status  = paddr_in == STATUS_OFS;
  wire logic [DIV_W-1:0] bit_cyc =
    (baud_sel == BAUD_SEL_150)  ? DIV_W'(P_BIT_CYC_150)  :
    (baud_sel == BAUD_SEL_300)  ? DIV_W'(P_BIT_CYC_300)  :
    (baud_sel == BAUD_SEL_600)  ? DIV_W'(P_BIT_CYC_600)  :
    (baud_sel == BAUD_SEL_1200) ? DIV_W'(P_BIT_CYC_1200) : DIV_W'(P_BIT_CYC_110);
  wire logic [31:0] status_word = {11'h000, state_r == S_LEAD, fg_entry_r, xmit_r, print_r,
                                   blink_r, 3'h0, row_r, 1'b0, col_r};

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      ctrl_r    <= CTRL_RST;
    end
    else
    begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup && !hit_ctrl && !hit_status;
      prdata_r  <= !apb_setup ? prdata_r :
                   hit_ctrl ? {26'h0000000, ctrl_r} :
                   hit_status ? status_word : 32'h0000_0000;
      if (apb_wr && hit_ctrl)
        ctrl_r <= pwdata_in[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // character-time enable from the baud divider
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_r       <= '0;
      bitcnt_r    <= 4'h0;
      char_tick_r <= 1'b0;
    end
    else
    begin
      char_tick_r <= 1'b0;
      if (div_r >= bit_cyc - DIV_W'(1))
      begin
        div_r <= '0;
        if (bitcnt_r == 4'(CHAR_BITS - 1))
        begin
          bitcnt_r    <= 4'h0;
          char_tick_r <= 1'b1;
        end
        else
          bitcnt_r <= bitcnt_r + 4'h1;
      end
      else
        div_r <= div_r + DIV_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interpreter
  task automatic emit(input tcc_op_t op, input logic [6:0] c, input logic bg);
    op_valid_r <= 1'b1;
    op_code_r  <= op;
    op_char_r  <= c;
    op_bg_r    <= bg;
  endtask

  task automatic home();
    row_r <= 5'h00;
    col_r <= 7'h00;
  endtask

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r     <= S_IDLE;
      pend_r      <= P_CHAR;
      row_r       <= 5'h00;
      col_r       <= 7'h00;
      char_r      <= 7'h00;
      line_r      <= 1'b0;
      fg_entry_r  <= 1'b0;
      blink_r     <= 1'b0;
      print_r     <= 1'b0;
      xmit_r      <= 1'b0;
      key_pend_r  <= 1'b0;
      scan_wait_r <= 1'b0;
      sym2_r      <= 1'b0;
      ready_r     <= 1'b0;
      op_valid_r  <= 1'b0;
      op_code_r   <= OP_NONE;
      op_char_r   <= 7'h00;
      op_bg_r     <= 1'b0;
    end
    else
    begin
      op_valid_r <= 1'b0;
      ready_r    <= 1'b0;
      if (foreground_clear_key_in)
        key_pend_r <= 1'b1;
      if (reset_button_in)
        fg_entry_r <= 1'b0;
      unique case (state_r)
        S_IDLE:
        begin
          ready_r <= 1'b1;
          if (accept)
          begin
            char_r <= rx_char_in;
            line_r <= rx_from_line_in;
            if (rx_char_in == LEAD_IN_CODE)
              state_r <= S_LEAD;
            else if (rx_char_in == TAB_CODE)
            begin
              ready_r <= 1'b0;
              if (!end_pos)
              begin
                state_r     <= S_TAB_BG;
                scan_wait_r <= 1'b1;
                row_r       <= next_row;
                col_r       <= next_col;
              end
            end
            else if (rx_char_in >= BLANK_CODE || is_cmd(rx_char_in) ||
                     rx_char_in == CR_CODE || rx_char_in == INSERT_CODE ||
                     rx_char_in == DELETE_CODE)
            begin
              ready_r <= 1'b0;
              state_r <= S_WAITBG;
              pend_r  <= (rx_char_in == CR_CODE) ? P_CR :
                         (rx_char_in == INSERT_CODE) ? P_INS :
                         (rx_char_in == DELETE_CODE) ? P_DEL : P_CHAR;
              if (is_cmd(rx_char_in))
                char_r <= BLANK_CODE;
            end
          end
          else if (key_pend_r && !foreground_clear_key_in)
          begin
            key_pend_r <= 1'b0;
            emit(OP_CLR_FG, 7'h00, 1'b0);
            home();
          end
        end
        S_LEAD:
        begin
          ready_r <= 1'b1;
          if (accept)
          begin
            state_r <= S_IDLE;
            unique case (rx_char_in)
              HOME_COMMAND_CODE: home();
              ROLL_DOWN_CODE, ALTERNATE_ROLL_DOWN_CODE:
                emit(OP_ROLL_DN, 7'h00, 1'b0);
              ROLL_UP_CODE: emit(OP_ROLL_UP, 7'h00, 1'b0);
              FOREGROUND_CLEAR_CODE:
              begin
                emit(OP_CLR_FG, 7'h00, 1'b0);
                home();
              end
              FULL_CLEAR_CODE:
              begin
                emit(OP_CLR_ALL, 7'h00, 1'b0);
                home();
              end
              CURSOR_ADDRESS_CODE:
              begin
                home();
                state_r <= S_ADDR1;
              end
              BLINK_ON_CODE: blink_r <= 1'b1;
              BLINK_OFF_CODE: blink_r <= 1'b0;
              FOREGROUND_ENTRY_CODE: fg_entry_r <= 1'b1;
              BACKGROUND_ENTRY_CODE: fg_entry_r <= 1'b0;
              PRINT_START_CODE:
              begin
                ready_r <= 1'b0;
                print_r <= 1'b1;
                sym2_r  <= 1'b0;
                state_r <= S_PRINT;
              end
              TRANSMIT_START_CODE:
              begin
                ready_r     <= 1'b0;
                xmit_r      <= 1'b1;
                scan_wait_r <= 1'b1;
                home();
                state_r     <= S_SCAN;
              end
              default: ;
            endcase
          end
        end
        S_ADDR1:
        begin
          ready_r <= 1'b1;
          if (accept)
          begin
            col_r   <= addr_col;
            state_r <= S_ADDR2;
          end
        end
        S_ADDR2:
        begin
          ready_r <= 1'b1;
          if (accept)
          begin
            row_r   <= addr_row;
            state_r <= S_IDLE;
          end
        end
        S_WAITBG:
        begin
          state_r <= S_IDLE;
          ready_r <= 1'b1;
          unique case (pend_r)
            P_CHAR:
            begin
              if (!protect)
                emit(OP_WRITE, char_r, entry_bg);
              if (!end_pos)
              begin
                row_r <= next_row;
                col_r <= next_col;
              end
              else if (local_echo)
              begin
                ready_r <= 1'b0;
                state_r <= S_ROLL;
              end
            end
            P_CR:
            begin
              if (row_r != LAST_ROW)
              begin
                row_r <= row_r + 5'h01;
                col_r <= 7'h00;
              end
              else if (local_echo)
              begin
                ready_r <= 1'b0;
                state_r <= S_ROLL;
              end
            end
            P_INS: emit(mem_bg_in ? OP_BLANKING : OP_INSERT, 7'h00, 1'b0);
            P_DEL: emit(mem_bg_in ? OP_BLANKING : OP_DELETE, 7'h00, 1'b0);
          endcase
        end
        S_ROLL:
        begin
          emit(OP_ROLL_UP, 7'h00, 1'b0);
          col_r   <= 7'h00;
          ready_r <= 1'b1;
          state_r <= S_IDLE;
        end
        S_TAB_BG, S_TAB_FG:
        begin
          scan_wait_r <= !scan_wait_r;
          if (!scan_wait_r)
          begin
            if (state_r == S_TAB_FG && !mem_bg_in)
            begin
              ready_r <= 1'b1;
              state_r <= S_IDLE;
            end
            else if (end_pos)
            begin
              ready_r <= 1'b1;
              state_r <= S_IDLE;
            end
            else
            begin
              if (mem_bg_in)
                state_r <= S_TAB_FG;
              row_r <= next_row;
              col_r <= next_col;
            end
          end
        end
        S_PRINT:
        begin
          emit(OP_WRITE, XMIT_SYMBOL_CODE, 1'b0);
          sym2_r <= 1'b1;
          if (!end_pos)
          begin
            row_r <= next_row;
            col_r <= next_col;
          end
          if (sym2_r)
          begin
            home();
            scan_wait_r <= 1'b1;
            state_r     <= S_SCAN;
          end
        end
        S_SCAN:
        begin
          if (scan_wait_r)
            scan_wait_r <= 1'b0;
          else if (xmit_r && mem_bg_in)
          begin
            scan_wait_r <= 1'b1;
            if (end_pos)
            begin
              xmit_r  <= 1'b0;
              ready_r <= 1'b1;
              state_r <= S_IDLE;
            end
            else
            begin
              row_r <= next_row;
              col_r <= next_col;
            end
          end
          else if (char_tick_r)
          begin
            emit(OP_SEND, 7'h00, mem_bg_in);
            scan_wait_r <= 1'b1;
            if (end_pos)
            begin
              xmit_r  <= 1'b0;
              print_r <= 1'b0;
              ready_r <= 1'b1;
              state_r <= S_IDLE;
            end
            else
            begin
              row_r <= next_row;
              col_r <= next_col;
            end
          end
        end
        default:
        begin
          ready_r <= 1'b1;
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata_out     = prdata_r;
  assign pready_out     = pready_r;
  assign pslverr_out    = pslverr_r;
  assign rx_ready_out   = ready_r;
  assign print_lamp_out = print_r;
  assign xmit_lamp_out  = xmit_r;
  assign blink_out      = blink_r;
  assign cur_row_out    = row_r;
  assign cur_col_out    = col_r;
  assign op_valid_out   = op_valid_r;
  assign op_code_out    = op_code_r;
  assign op_char_out    = op_char_r;
  assign op_bg_out      = op_bg_r;

endmodule

// ---- tcc_interp_props.sv ----
`timescale 1ns/100ps
module tcc_interp_props
  import tcc_pkg::*;
(
  // watched ports
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [11:0] paddr_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        rx_valid_in,
  input wire logic [6:0]  rx_char_in,
  input wire logic        rx_ready_out,
  input wire logic        blink_out,
  input wire logic [4:0]  cur_row_out,
  input wire logic [6:0]  cur_col_out,
  input wire logic        op_valid_out,
  input wire logic [3:0]  op_code_out,
  input wire logic [6:0]  op_char_out
);
  logic lead_r;
  wire  take = rx_valid_in && rx_ready_out;
  always_ff @(posedge clk_sys_in or posedge rst_in)
    if (rst_in)
      lead_r <= 1'b0;
    else if (take)
      lead_r <= (rx_char_in == LEAD_IN_CODE) && !lead_r;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////
  AST_READY: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready in access phase");
  AST_READY_ONE: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  AST_SLVERR: assert property (pready_out && paddr_in != CTRL_OFS
    && paddr_in != STATUS_OFS |-> pslverr_out) else $error("no error on unmapped");
  AST_HOME: assert property (
    take && lead_r && rx_char_in == HOME_COMMAND_CODE |=> cur_row_out == 0 && cur_col_out == 0)
    else $error("cursor not homed");
  AST_BLANK: assert property (
    take && !lead_r && rx_char_in == ROLL_UP_CODE |-> ##2 op_valid_out
    && op_code_out == OP_WRITE && op_char_out == BLANK_CODE) else $error("no blank write");
  AST_ROLL_UP: assert property (
    take && lead_r && rx_char_in == ROLL_UP_CODE |-> ##[1:4] op_valid_out
    && op_code_out == OP_ROLL_UP) else $error("no roll up");
  AST_ROLL_DN: assert property (
    take && lead_r && rx_char_in == ROLL_DOWN_CODE |-> ##[1:4] op_valid_out
    && op_code_out == OP_ROLL_DN) else $error("no roll down");
  AST_BLINK_ON: assert property (
    take && lead_r && rx_char_in == BLINK_ON_CODE |=> blink_out && $stable(cur_col_out))
    else $error("blink not started");
  AST_BLINK_OFF: assert property (
    take && lead_r && rx_char_in == BLINK_OFF_CODE |=> !blink_out)
    else $error("blink not stopped");
endmodule
bind tcc_interp tcc_interp_props chk_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .rx_valid_in(rx_valid_in), .rx_char_in(rx_char_in),
  .rx_ready_out(rx_ready_out), .blink_out(blink_out), .cur_row_out(cur_row_out),
  .cur_col_out(cur_col_out), .op_valid_out(op_valid_out), .op_code_out(op_code_out),
  .op_char_out(op_char_out));

// ---- tcc_pkg.sv ----
package tcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and link rates
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned BAUD_110    = 110;
  localparam int unsigned BAUD_150    = 150;
  localparam int unsigned BAUD_300    = 300;
  localparam int unsigned BAUD_600    = 600;
  localparam int unsigned BAUD_1200   = 1200;
  localparam int unsigned CHAR_BITS   = 11;
  localparam int unsigned DIV_W       = 19;

  ////////////////////////////////////////////////////////////////////////////
  // screen geometry
  localparam logic [4:0] LAST_ROW     = 5'h1a;
  localparam logic [6:0] LAST_COL     = 7'h49;

  ////////////////////////////////////////////////////////////////////////////
  // character codes, 7 bits, bit 7 of the i/o path is bit [6]
  localparam logic [6:0] LEAD_IN_CODE                  = 7'h1b;
  localparam logic [6:0] HOME_COMMAND_CODE             = 7'h12;
  localparam logic [6:0] ROLL_DOWN_CODE                = 7'h1a;
  localparam logic [6:0] ALTERNATE_ROLL_DOWN_CODE      = 7'h0b;
  localparam logic [6:0] ROLL_UP_CODE                  = 7'h0c;
  localparam logic [6:0] FOREGROUND_CLEAR_CODE         = 7'h1d;
  localparam logic [6:0] FULL_CLEAR_CODE               = 7'h1c;
  localparam logic [6:0] CURSOR_ADDRESS_CODE           = 7'h11;
  localparam logic [6:0] FOREGROUND_ENTRY_CODE         = 7'h19;
  localparam logic [6:0] BACKGROUND_ENTRY_CODE         = 7'h15;
  localparam logic [6:0] PRINT_START_CODE              = 7'h0e;
  localparam logic [6:0] TRANSMIT_START_CODE           = 7'h0f;
  localparam logic [6:0] BLINK_ON_CODE                 = 7'h2f;
  localparam logic [6:0] BLINK_OFF_CODE                = 7'h3f;
  localparam logic [6:0] CR_CODE                       = 7'h0d;
  localparam logic [6:0] TAB_CODE                      = 7'h09;
  localparam logic [6:0] INSERT_CODE                   = 7'h16;
  localparam logic [6:0] DELETE_CODE                   = 7'h17;
  localparam logic [6:0] BLANK_CODE                    = 7'h20;
  localparam logic [6:0] XMIT_SYMBOL_CODE              = 7'h04;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] STATUS_OFS  = 12'h004;
  localparam logic [5:0]  CTRL_RST    = 6'h00;
  localparam int unsigned CTRL_LOCAL_ECHO = 0;
  localparam int unsigned CTRL_LOCAL_EDIT = 1;
  localparam int unsigned CTRL_FULL_DUP   = 2;
  localparam int unsigned CTRL_BAUD_LSB   = 3;
  localparam int unsigned ST_ROW_LSB      = 8;
  localparam int unsigned ST_BLINK        = 16;
  localparam int unsigned ST_PRINT        = 17;
  localparam int unsigned ST_XMIT         = 18;
  localparam int unsigned ST_FG_ENTRY     = 19;
  localparam int unsigned ST_LEAD         = 20;

  ////////////////////////////////////////////////////////////////////////////
  // baud select and display operations
  typedef enum logic [2:0] {
    BAUD_SEL_110  = 3'b000,
    BAUD_SEL_150  = 3'b001,
    BAUD_SEL_300  = 3'b010,
    BAUD_SEL_600  = 3'b011,
    BAUD_SEL_1200 = 3'b100
  } tcc_baud_t;

  typedef enum logic [3:0] {
    OP_NONE     = 4'b0000,
    OP_WRITE    = 4'b0001,
    OP_ROLL_UP  = 4'b0010,
    OP_ROLL_DN  = 4'b0011,
    OP_CLR_FG   = 4'b0100,
    OP_CLR_ALL  = 4'b0101,
    OP_INSERT   = 4'b0110,
    OP_DELETE   = 4'b0111,
    OP_BLANKING = 4'b1000,
    OP_SEND     = 4'b1001
  } tcc_op_t;

endpackage

// ---- test_tcc_interp.sv ----
`timescale 1ns/100ps
module test_tcc_interp;
  import tcc_pkg::*;
  logic        clk_sys_in = 1'b0, rst_in = 1'b1;
  logic        psel = 0, penable = 0, pwrite = 0, bgb = 0, rbtn = 0, fgk = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  logic        e, pready, pslverr, rxv, rxl, rxr, blink, opv, opbg, lbg, pl, xl;
  logic [6:0]  rxc, col, opch, lch;
  logic [4:0]  row;
  logic [3:0]  opc, lop;
  int          err_total = 0, check_count = 0, nop = 0, i;
  tcc_op_t     oc[4] = '{OP_ROLL_UP, OP_ROLL_DN, OP_CLR_FG, OP_CLR_ALL};
  logic [6:0]  cd[4] = '{ROLL_UP_CODE, ROLL_DOWN_CODE, FOREGROUND_CLEAR_CODE, FULL_CLEAR_CODE};
  always #12.5 clk_sys_in = ~clk_sys_in;
  tcc_interp dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rx_valid_in(rxv),
    .rx_char_in(rxc), .rx_from_line_in(rxl), .rx_ready_out(rxr), .reset_button_in(rbtn),
    .foreground_clear_key_in(fgk), .print_lamp_out(pl), .xmit_lamp_out(xl), .blink_out(blink),
    .mem_bg_in(bgb), .cur_row_out(row), .cur_col_out(col), .op_valid_out(opv),
    .op_code_out(opc), .op_char_out(opch), .op_bg_out(opbg));
  tcc_host_model host_u (.clk_in(clk_sys_in), .ready_in(rxr), .valid_out(rxv),
    .char_out(rxc), .line_out(rxl));
  always @(posedge clk_sys_in)
    if (opv === 1'b1)
    begin
      lop <= opc;
      lch <= opch;
      lbg <= opbg;
      nop <= nop + 1;
    end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do
      @(posedge clk_sys_in);
    while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic sc(input logic [6:0] c, input logic ln = 1'b0);
    host_u.send(c, ln, 0);
    repeat (4) @(posedge clk_sys_in);
  endtask
  task automatic ld(input logic [6:0] c);
    sc(LEAD_IN_CODE);
    sc(c);
  endtask
  task automatic idle();
    while (rxr !== 1'b1)
      @(posedge clk_sys_in);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    err_total++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    apb(0, CTRL_OFS, 0);
    chk(rd, 32'(CTRL_RST));
    apb(1, CTRL_OFS, 32'hffff_ffe6);
    apb(0, CTRL_OFS, 0);
    chk(rd, 32'h0000_0026);
    apb(1, 12'h008, 32'h1);
    chk(e, 1);
    sc(7'h41);
    chk(lch, 7'h41);
    sc(ROLL_UP_CODE);
    chk({lch, col}, {BLANK_CODE, 7'h02});
    ld(HOME_COMMAND_CODE);
    chk({row, col}, 0);
    ld(CURSOR_ADDRESS_CODE);
    chk({row, col}, 0);
    i = nop;
    sc(7'h05);
    sc(7'h03);
    chk({row, col, 20'(nop)}, {5'h03, 7'h05, 20'(i)});
    ld(BLINK_ON_CODE);
    apb(0, STATUS_OFS, 0);
    chk({blink, rd[ST_BLINK], col}, {2'b11, 7'h05});
    ld(BLINK_OFF_CODE);
    chk(blink, 0);
    ld(FOREGROUND_ENTRY_CODE);
    chk(col, 7'h05);
    sc(7'h58);
    chk(lbg, 0);
    rbtn <= 1'b1;
    @(posedge clk_sys_in);
    rbtn <= 1'b0;
    sc(7'h58);
    chk(lbg, 1);
    ld(FOREGROUND_ENTRY_CODE);
    ld(BACKGROUND_ENTRY_CODE);
    sc(7'h58);
    chk(lbg, 1);
    ld(FOREGROUND_ENTRY_CODE);
    sc(7'h41, 1'b1);
    chk(lbg, 1);
    bgb <= 1'b1;
    sc(INSERT_CODE);
    chk(lop, OP_BLANKING);
    bgb <= 1'b0;
    i = col;
    sc(INSERT_CODE);
    chk({lop, col}, {OP_INSERT, 7'(i)});
    for (i = 0; i < 4; i++)
    begin
      ld(cd[i]);
      chk(lop, oc[i]);
      if (i > 1)
        chk({row, col}, 0);
    end
    sc(TAB_CODE);
    idle();
    chk({row, col}, {LAST_ROW, LAST_COL});
    sc(TAB_CODE);
    chk({row, col}, {LAST_ROW, LAST_COL});
    apb(1, CTRL_OFS, 32'h0000_0003);
    sc(7'h51);
    chk({lop, row, col}, {OP_ROLL_UP, LAST_ROW, 7'h00});
    bgb <= 1'b1;
    i = nop;
    sc(7'h42);
    chk({col, 25'(nop)}, {7'h01, 25'(i)});
    ld(TRANSMIT_START_CODE);
    chk(xl, 1);
    idle();
    chk({xl, row, col, 19'(nop)}, {1'b0, LAST_ROW, LAST_COL, 19'(i)});
    bgb <= 1'b0;
    ld(PRINT_START_CODE);
    chk({pl, lch, 24'(nop)}, {1'b1, XMIT_SYMBOL_CODE, 24'(i + 2)});
    rst_in <= 1'b1;
    @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk(pl, 0);
    fgk <= 1'b1;
    @(posedge clk_sys_in);
    fgk <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chk(lop, OP_CLR_FG);
    finish_test();
  end
endmodule
